// File: verilog/imrc_cmd_interp.sv
// interpolation mode and data read-back command interpreter
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "imrc_defs.svh"

module imrc_cmd_interp #(
  parameter int NUM_AXES = 4,
  parameter int DATA_W = 32,
  parameter logic [7:0] IRQ_CLEAR_CODE = 8'h6d,
  parameter logic [7:0] NEXT_NODE_CODE = 8'h6e,
  parameter logic [7:0] MODE_READ_CODE = 8'h3c
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_AXES-1:0][DATA_W-1:0] logical_position_count_i,
  input wire logic [NUM_AXES-1:0][DATA_W-1:0] real_position_count_i,
  input wire logic [NUM_AXES-1:0][DATA_W-1:0] present_velocity_i,
  input wire logic [NUM_AXES-1:0][DATA_W-1:0] present_ramp_rate_i,
  input wire logic [NUM_AXES-1:0][DATA_W-1:0] general_hold_zero_i,
  input wire logic [NUM_AXES-1:0][DATA_W-1:0] general_hold_one_i,
  input wire logic [NUM_AXES-1:0] axis_driving_i,
  input wire logic interp_active_i,
  input wire logic [3:0] stack_count_i,
  input wire logic cont_interp_done_i,
  input wire logic ext_advance_pulse_n_i,
  output logic [NUM_AXES-1:0] interp_axis_en_o,
  output logic [NUM_AXES-1:0] main_axis_o,
  output logic circle_axis_swap_o,
  output logic [1:0] vector_speed_sel_o,
  output logic short_axis_equalize_o,
  output logic interp_step_o,
  output logic [1:0] multichip_role_o,
  output logic manual_finish_max_o,
  output logic [1:0] fifo_irq_sel_o,
  output logic interp_irq_n_o,
  output logic [15:0] result_low_reg_o,
  output logic [15:0] result_high_reg_o
);

  imrc_pkg::imrc_core_state_type q, d;

  logic bus_req;
  logic wr_take;
  logic [7:0] wr_code;
  logic [3:0] wr_axis;
  logic cmd_write;
  logic axis_onehot;
  logic is_read_code;
  logic irq_event;
  logic irq_clear;
  logic [NUM_AXES-1:0] main_sel;
  logic [1:0] rd_idx;
  logic [DATA_W-1:0] rd_value;
  logic rd_two_byte;
  logic rd_load;
  logic [31:0] status_word;

  if (NUM_AXES != 4 || DATA_W != 32) begin : g_chk
    $error("imrc_cmd_interp serves four axes of 32-bit data only");
  end

  // bus request decode; writes land at the edge ack is sampled
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wr_take = bus_req && wb_we_i && q.ack;
  assign wr_code = wb_dat_i[`IMRC_CMD_CODE_LSB +: 8];
  assign wr_axis = wb_dat_i[`IMRC_CMD_AXIS_LSB +: 4];
  assign cmd_write = wr_take && (wb_adr_i == `IMRC_ADR_CMD) &&
                     wb_sel_i[0];
  assign axis_onehot = $onehot(wr_axis);
  assign is_read_code = (wr_code >= `IMRC_CODE_RD_LOGPOS) &&
                        (wr_code <= `IMRC_CODE_RD_HOLD1);

  // fixed priority X, Y, Z, U
  always_comb begin
    main_sel = '0;
    for (int i = NUM_AXES - 1; i >= 0; i--) begin
      if (q.mode[`IMRC_MODE_AXIS_LSB + i]) begin
        main_sel = '0;
        main_sel[i] = 1'b1;
      end
    end
  end

  // stack count transitions picked by mode
  assign irq_event =
    (q.mode[`IMRC_MODE_IRQ_LSB] && q.stack_prev == `IMRC_STK_4 &&
     stack_count_i == `IMRC_STK_3) ||
    (q.mode[`IMRC_MODE_IRQ_HI] && q.stack_prev == `IMRC_STK_8 &&
     stack_count_i == `IMRC_STK_7);

  // three ways to release the interrupt
  assign irq_clear = cont_interp_done_i ||
    (cmd_write && (wr_code == IRQ_CLEAR_CODE ||
                   wr_code == NEXT_NODE_CODE));

  // index of the single axis named by the pending read
  always_comb begin
    rd_idx = 2'd0;
    for (int i = 0; i < NUM_AXES; i++) begin
      if (q.rd_axis[i]) begin
        rd_idx = 2'(i);
      end
    end
  end

  // select the requested value, sampled in one cycle
  always_comb begin
    rd_value = '0;
    rd_two_byte = 1'b0;
    // values passed bit for bit, sign kept
    unique case (q.rd_code)
      // position counters, two's complement as held
      `IMRC_CODE_RD_LOGPOS: rd_value = logical_position_count_i[rd_idx];
      `IMRC_CODE_RD_REALPOS: rd_value = real_position_count_i[rd_idx];
      `IMRC_CODE_RD_VELO: begin
        // zero when stopped, only main axis in interpolation
        if (axis_driving_i[rd_idx] &&
            (!interp_active_i || main_sel[rd_idx])) begin
          rd_value = present_velocity_i[rd_idx];
        end
      end
      `IMRC_CODE_RD_RAMP: begin
        if (axis_driving_i[rd_idx]) begin
          rd_value = present_ramp_rate_i[rd_idx];
        end
      end
      // general hold registers, signed 32 bits
      `IMRC_CODE_RD_HOLD0: rd_value = general_hold_zero_i[rd_idx];
      `IMRC_CODE_RD_HOLD1: rd_value = general_hold_one_i[rd_idx];
      MODE_READ_CODE: begin
        // mode word is a two-byte answer
        rd_value = {16'h0000, q.mode};
        rd_two_byte = 1'b1;
      end
      default: rd_value = '0;
    endcase
  end

  // latch one cycle after the command
  assign rd_load = (q.rd == imrc_pkg::IMRC_LATCH);

  // status word seen by software
  always_comb begin
    status_word = '0;
    status_word[`IMRC_ST_BUSY] = rd_load;
    status_word[`IMRC_ST_IRQ] = q.irq;
    status_word[`IMRC_ST_AXERR] = q.err;
    status_word[`IMRC_ST_MAIN_LSB +: 4] = main_sel;
    status_word[`IMRC_ST_MODE_LSB +: 16] = q.mode;
  end

  // next state of the whole block
  always_comb begin
    d = q;
    d.ack = bus_req && !q.ack;
    d.step = 1'b0;
    d.ext_prev = ext_advance_pulse_n_i;
    d.stack_prev = stack_count_i;
    d.rd = imrc_pkg::IMRC_IDLE;
    // read data captured with the ack
    if (bus_req && !q.ack && !wb_we_i) begin
      unique case (wb_adr_i)
        `IMRC_ADR_RES_LO: d.rdat = {16'h0000, result_low_reg_o};
        `IMRC_ADR_RES_HI: d.rdat = {16'h0000, result_high_reg_o};
        `IMRC_ADR_STATUS: d.rdat = status_word;
        default: d.rdat = '0;
      endcase
    end
    // parameter word holding register, per byte lane
    if (wr_take && wb_adr_i == `IMRC_ADR_PARAM) begin
      if (wb_sel_i[0]) begin
        d.param[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        d.param[15:8] = wb_dat_i[15:8];
      end
    end
    if (cmd_write) begin
      // mode load is global, axis field ignored
      if (wr_code == `IMRC_CODE_MODE) begin
        d.mode = q.param & ~`IMRC_MODE_RESV_MASK;
      end
      // single-step command only in step mode
      if (wr_code == `IMRC_CODE_STEP) begin
        d.step = q.mode[`IMRC_MODE_STEP];
      end
      if (wr_code == MODE_READ_CODE) begin
        d.rd = imrc_pkg::IMRC_LATCH;
        d.rd_code = wr_code;
      end
      // a read naming other than one axis is refused
      if (is_read_code) begin
        if (axis_onehot && wb_sel_i[1]) begin
          d.rd = imrc_pkg::IMRC_LATCH;
          d.rd_code = wr_code;
          d.rd_axis = wr_axis;
          d.err = 1'b0;
        end else begin
          d.err = 1'b1;
        end
      end
    end
    // falling edge of the external advance pulse
    if (q.ext_prev && !ext_advance_pulse_n_i &&
        q.mode[`IMRC_MODE_STEP]) begin
      d.step = 1'b1;
    end
    // a new event wins over a clear in the same cycle
    d.irq = irq_event || (q.irq && !irq_clear);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.mode <= `IMRC_MODE_RESET;
      q.ext_prev <= 1'b1;
      q.rd <= imrc_pkg::IMRC_IDLE;
    end else begin
      q <= d;
    end
  end

  // one-edge capture of the selected value
  imrc_result_latch #(
    .DATA_W(DATA_W)
  ) u_result (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(rd_load),
    .two_byte_i(rd_two_byte),
    .value_i(rd_value),
    .result_low_o(result_low_reg_o),
    .result_high_o(result_high_reg_o)
  );

  // mode word fields driven out to the interpolation engine
  // axis enables
  assign interp_axis_en_o = q.mode[`IMRC_MODE_AXIS_LSB +: 4];
  assign main_axis_o = main_sel;
  assign circle_axis_swap_o = q.mode[`IMRC_MODE_SWAP];
  assign vector_speed_sel_o = q.mode[`IMRC_MODE_VSPD_LSB +: 2];
  assign short_axis_equalize_o = q.mode[`IMRC_MODE_EQUAL];
  assign multichip_role_o = q.mode[`IMRC_MODE_MLT_LSB +: 2];
  assign manual_finish_max_o = q.mode[`IMRC_MODE_FMAX];
  assign fifo_irq_sel_o = q.mode[`IMRC_MODE_IRQ_LSB +: 2];
  assign interp_step_o = q.step;
  assign interp_irq_n_o = !q.irq;
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;

  // checks
  localparam int RD_MAX = `IMRC_RD_MAX_CYC;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read_taken;
    cmd_write && is_read_code && axis_onehot && wb_sel_i[1];
  endsequence

  sequence s_read_done;
    !status_word[`IMRC_ST_BUSY];
  endsequence

  a_mode_load_word: assert property (
    cmd_write && wr_code == `IMRC_CODE_MODE |=>
    interp_axis_en_o == $past(q.param[3:0]) &&
    manual_finish_max_o == $past(q.param[12]))
    else $error("mode word not loaded by mode command");

  a_main_axis_prio: assert property (
    $onehot0(main_axis_o) &&
    (interp_axis_en_o[0] -> main_axis_o[0]) &&
    (interp_axis_en_o[1:0] == 2'b10 -> main_axis_o[1]))
    else $error("main axis not first enabled axis");

  a_resv_bits_zero: assert property (
    status_word[`IMRC_ST_MODE_LSB + 5] == 1'b0 &&
    status_word[`IMRC_ST_MODE_LSB + 13] == 1'b0)
    else $error("reserved mode bit stored as one");

  a_step_needs_mode: assert property (
    interp_step_o |-> $past(q.mode[`IMRC_MODE_STEP]))
    else $error("step pulse outside single-step mode");

  a_irq_on_event: assert property (
    irq_event |=> !interp_irq_n_o ##1
    (!interp_irq_n_o || $past(irq_clear)))
    else $error("stack transition did not assert interrupt");

  a_irq_release: assert property (
    !irq_event && cont_interp_done_i |=> interp_irq_n_o)
    else $error("interrupt not released at finish");

  a_read_ready: assert property (
    s_read_taken |=> ##[0:RD_MAX] s_read_done)
    else $error("read result not ready in time");

  a_bad_axis_flag: assert property (
    cmd_write && is_read_code && !axis_onehot |=>
    status_word[`IMRC_ST_AXERR] && !rd_load)
    else $error("read with bad axis selection not refused");

  a_stopped_velo: assert property (
    rd_load && q.rd_code == `IMRC_CODE_RD_VELO &&
    !axis_driving_i[rd_idx] |=> result_low_reg_o == 16'h0000 &&
    result_high_reg_o == 16'h0000)
    else $error("stopped axis reported nonzero speed");

endmodule

`default_nettype wire

// File: verilog/imrc_defs.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef IMRC_DEFS_SVH
`define IMRC_DEFS_SVH

// wishbone byte addresses
`define IMRC_ADR_CMD 8'h00
`define IMRC_ADR_PARAM 8'h04
`define IMRC_ADR_RES_LO 8'h08
`define IMRC_ADR_RES_HI 8'h0c
`define IMRC_ADR_STATUS 8'h10

// command register fields
`define IMRC_CMD_CODE_LSB 0
`define IMRC_CMD_AXIS_LSB 8

// command codes
`define IMRC_CODE_MODE 8'h2a
`define IMRC_CODE_STEP 8'h6f
`define IMRC_CODE_RD_LOGPOS 8'h30
`define IMRC_CODE_RD_REALPOS 8'h31
`define IMRC_CODE_RD_VELO 8'h32
`define IMRC_CODE_RD_RAMP 8'h33
`define IMRC_CODE_RD_HOLD0 8'h34
`define IMRC_CODE_RD_HOLD1 8'h35

// interpolation mode word fields
`define IMRC_MODE_AXIS_LSB 0
`define IMRC_MODE_SWAP 4
`define IMRC_MODE_VSPD_LSB 6
`define IMRC_MODE_EQUAL 8
`define IMRC_MODE_STEP 9
`define IMRC_MODE_MLT_LSB 10
`define IMRC_MODE_FMAX 12
`define IMRC_MODE_IRQ_LSB 14
`define IMRC_MODE_IRQ_HI 15
`define IMRC_MODE_RESV_MASK 16'h2020
`define IMRC_MODE_RESET 16'h0000

// status register fields
`define IMRC_ST_BUSY 0
`define IMRC_ST_IRQ 1
`define IMRC_ST_AXERR 2
`define IMRC_ST_MAIN_LSB 4
`define IMRC_ST_MODE_LSB 16

// pre-buffer stack count transitions
`define IMRC_STK_4 4'h4
`define IMRC_STK_3 4'h3
`define IMRC_STK_8 4'h8
`define IMRC_STK_7 4'h7

// read answer time
`define IMRC_CLK_MHZ 40
`define IMRC_RD_MAX_NS 125
`define IMRC_RD_MAX_CYC ((`IMRC_RD_MAX_NS * `IMRC_CLK_MHZ) / 1000)

`endif

// File: verilog/imrc_pkg.sv
// types shared by the command interpreter files
package imrc_pkg;

  typedef enum logic {
    IMRC_IDLE,
    IMRC_LATCH
  } imrc_rd_state_type;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] param;
    logic ack;
    logic [31:0] rdat;
    imrc_rd_state_type rd;
    logic [7:0] rd_code;
    logic [3:0] rd_axis;
    logic irq;
    logic err;
    logic ext_prev;
    logic [3:0] stack_prev;
    logic step;
  } imrc_core_state_type;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
  } imrc_latch_state_type;

endpackage

// File: verilog/imrc_result_latch.sv
// result register pair loaded in one edge from a sampled value
`timescale 1ns/1ps
`default_nettype none
`include "imrc_defs.svh"

module imrc_result_latch #(
  parameter int DATA_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic two_byte_i,
  input wire logic [DATA_W-1:0] value_i,
  output logic [DATA_W/2-1:0] result_low_o,
  output logic [DATA_W/2-1:0] result_high_o
);

  imrc_pkg::imrc_latch_state_type q, d;

  if (DATA_W != 32) begin : g_chk
    $error("imrc_result_latch serves only 32-bit results");
  end

  // both halves taken from the same sample
  always_comb begin
    d = q;
    if (load_i) begin
      // low half low, high half high
      d.lo = value_i[15:0];
      d.hi = two_byte_i ? 16'h0000 : value_i[31:16];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign result_low_o = q.lo;
  assign result_high_o = q.hi;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_two_byte_high: assert property (load_i && two_byte_i |=>
    result_high_o == 16'h0000 && result_low_o == $past(value_i[15:0]))
    else $error("two-byte result left upper half nonzero");

  a_four_byte_pair: assert property (load_i && !two_byte_i |=>
    {result_high_o, result_low_o} == $past(value_i))
    else $error("four-byte result halves not from one sample");

endmodule

`default_nettype wire

// File: sim/imrc_engine_model.sv
// engine stand-in that supplies per-axis counters and rates
`timescale 1ns/1ps
`default_nettype none

module imrc_engine_model (
  input wire logic [7:0] prefix_i,
  output logic [3:0][31:0] log_pos_o,
  output logic [3:0][31:0] real_pos_o,
  output logic [3:0][31:0] velo_o,
  output logic [3:0][31:0] rate_o,
  output logic [3:0][31:0] hold0_o,
  output logic [3:0][31:0] hold1_o
);
  // each value names its source and axis; a high prefix makes it negative
  always_comb begin
    for (int a = 0; a < 4; a++) begin
      log_pos_o[a] = {prefix_i, 8'h10, 12'h000, 4'(a)};
      real_pos_o[a] = {prefix_i, 8'h11, 12'h000, 4'(a)};
      velo_o[a] = {prefix_i, 8'h12, 12'h000, 4'(a)};
      rate_o[a] = {prefix_i, 8'h13, 12'h000, 4'(a)};
      hold0_o[a] = {prefix_i, 8'h14, 12'h000, 4'(a)};
      hold1_o[a] = {prefix_i, 8'h15, 12'h000, 4'(a)};
    end
  end
endmodule

`default_nettype wire

// File: sim/imrc_cmd_interp_tb.sv
// self-checking bench for the mode and read-back command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "imrc_defs.svh"

module imrc_cmd_interp_tb;
  typedef struct {logic [7:0] code; int ai; logic [31:0] exp;} imrc_row_type;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = 8'h00, prefix = 8'h9c;
  logic [3:0] sel = 4'h0, drv = 4'hf, stk = 4'h0, lanes = 4'hf;
  logic [3:0] en_o, main_o;
  logic [31:0] dw = 32'h0, dr, q;
  logic iact = 0, done = 0, extn = 1, swap, equal, step, fmax, irq_n;
  logic [1:0] vspd, role, isel;
  logic [15:0] rlo, rhi;
  logic [3:0][31:0] log_pos, real_pos, velo, rate, hold0, hold1;
  int num_errors = 0, comparisons = 0, steps = 0;
  logic [3:0] pri [5] = '{4'h8, 4'hc, 4'ha, 4'h6, 4'h3};
  imrc_row_type rows [6] = '{'{8'h30, 0, 32'h9c10_0000},
    '{8'h31, 1, 32'h9c11_0001}, '{8'h32, 2, 32'h9c12_0002},
    '{8'h33, 3, 32'h9c13_0003}, '{8'h34, 0, 32'h9c14_0000},
    '{8'h35, 3, 32'h9c15_0003}};
  // mode fields placed at their mode word positions
  wire logic [15:0] fld = {isel, 1'b0, fmax, role, 1'b0, equal, vspd,
    1'b0, swap, en_o};

  initial forever #12.5 clk_i = ~clk_i;

  // count step pulses seen at the pin
  always @(posedge clk_i) if (step === 1'b1) steps <= steps + 1;

  imrc_engine_model engine (.prefix_i(prefix), .log_pos_o(log_pos),
    .real_pos_o(real_pos), .velo_o(velo), .rate_o(rate),
    .hold0_o(hold0), .hold1_o(hold1));

  imrc_cmd_interp DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .logical_position_count_i(log_pos), .real_position_count_i(real_pos),
    .present_velocity_i(velo), .present_ramp_rate_i(rate),
    .general_hold_zero_i(hold0), .general_hold_one_i(hold1),
    .axis_driving_i(drv), .interp_active_i(iact), .stack_count_i(stk),
    .cont_interp_done_i(done), .ext_advance_pulse_n_i(extn),
    .interp_axis_en_o(en_o), .main_axis_o(main_o),
    .circle_axis_swap_o(swap), .vector_speed_sel_o(vspd),
    .short_axis_equalize_o(equal), .interp_step_o(step),
    .multichip_role_o(role), .manual_finish_max_o(fmax),
    .fifo_irq_sel_o(isel), .interp_irq_n_o(irq_n),
    .result_low_reg_o(rlo), .result_high_reg_o(rhi));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= lanes;
    dw <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
    r = dr;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
  endtask

  task automatic cmd(input logic [3:0] ax, input logic [7:0] c);
    wb(1'b1, `IMRC_ADR_CMD, {20'h0, ax, c}, q);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, q);
  endtask

  task automatic mode(input logic [15:0] m);
    wb(1'b1, `IMRC_ADR_PARAM, {16'h0, m}, q);
    cmd(4'h0, `IMRC_CODE_MODE);
    repeat (2) @(posedge clk_i);
  endtask

  // host waits 125 ns, five cycles at 40 MHz, then reads both halves
  task automatic result(input logic [31:0] e);
    repeat (5) @(posedge clk_i);
    rd(`IMRC_ADR_RES_LO);
    chk("res_lo", {16'h0, e[15:0]}, q);
    rd(`IMRC_ADR_RES_HI);
    chk("res_hi", {16'h0, e[31:16]}, q);
    chk("res_pins", e, {rhi, rlo});
  endtask

  task automatic stack(input logic [3:0] a, input logic [3:0] b);
    stk <= a;
    @(posedge clk_i);
    stk <= b;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    int m;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("fields", 32'h0, fld);
    chk("irq_n", 32'h1, irq_n);
    chk("results", 32'h0, {rhi, rlo});
    $display("test reset done");
    foreach (rows[i]) begin
      cmd(4'h1 << rows[i].ai, rows[i].code);
      result(rows[i].exp);
    end
    $display("test read rows done");
    for (int b = 0; b < 16; b++) begin
      mode(16'h1 << b);
      chk("fields", {16'h0, 16'h1 << b & 16'hdddf}, fld);
    end
    mode(16'hffff);
    chk("fields", 32'hdddf, fld);
    rd(`IMRC_ADR_STATUS);
    chk("status_mode", 32'hdfdf, {16'h0, q[31:16]});
    cmd(4'h0, 8'h3c);
    result(32'h0000_dfdf);
    foreach (pri[i]) begin
      mode({12'h0, pri[i]});
      chk("main_axis", pri[i] & (~pri[i] + 4'h1), main_o);
    end
    $display("test mode fields done");
    mode(16'h0006);
    iact <= 1;
    cmd(4'h4, `IMRC_CODE_RD_VELO);
    result(32'h0);
    cmd(4'h2, `IMRC_CODE_RD_VELO);
    result(32'h9c12_0001);
    iact <= 0;
    drv <= 4'hb;
    cmd(4'h4, `IMRC_CODE_RD_VELO);
    result(32'h0);
    cmd(4'h4, `IMRC_CODE_RD_RAMP);
    result(32'h0);
    drv <= 4'hf;
    cmd(4'h3, `IMRC_CODE_RD_LOGPOS);
    result(32'h0);
    rd(`IMRC_ADR_STATUS);
    chk("axis_err", 32'h1, q[2]);
    rd(8'h20);
    chk("unmapped", 32'h0, q);
    $display("test zero and refused reads done");
    mode(16'h4000);
    stack(4'h4, 4'h3);
    chk("irq_n", 32'h0, irq_n);
    cmd(4'h0, 8'h6d);
    chk("irq_n", 32'h1, irq_n);
    mode(16'h8000);
    stack(4'h4, 4'h3);
    chk("irq_n", 32'h1, irq_n);
    stack(4'h8, 4'h7);
    chk("irq_n", 32'h0, irq_n);
    cmd(4'h0, 8'h6e);
    chk("irq_n", 32'h1, irq_n);
    stack(4'h8, 4'h7);
    done <= 1;
    @(posedge clk_i);
    done <= 0;
    repeat (3) @(posedge clk_i);
    chk("irq_n", 32'h1, irq_n);
    $display("test interrupt done");
    mode(16'h0200);
    m = steps;
    cmd(4'h0, `IMRC_CODE_STEP);
    repeat (3) @(posedge clk_i);
    chk("steps", m + 1, steps);
    extn <= 0;
    repeat (3) @(posedge clk_i);
    extn <= 1;
    repeat (3) @(posedge clk_i);
    chk("steps", m + 2, steps);
    $display("test step done");
    // reset in mid-run with a result held and the mode word set
    cmd(4'h1, `IMRC_CODE_RD_LOGPOS);
    result(32'h9c10_0000);
    mode(16'h4fff);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("fields", 32'h0, fld);
    chk("results", 32'h0, {rhi, rlo});
    $display("test mid-run reset done");
    // low byte lane only: half a parameter word, read refused
    lanes = 4'h1;
    wb(1'b1, `IMRC_ADR_PARAM, 32'h0000_ffff, q);
    cmd(4'h1, `IMRC_CODE_RD_LOGPOS);
    lanes = 4'hf;
    rd(`IMRC_ADR_STATUS);
    chk("lane_err", 32'h1, q[2]);
    cmd(4'h0, `IMRC_CODE_MODE);
    chk("fields", 32'h00df, fld);
    $display("test byte lanes done");
    mode(16'h0000);
    chk("fields", 32'h0, fld);
    $display("test clear done");
    conclude();
  end
endmodule

`default_nettype wire
